// >>> src/accel_pkg.sv
package accel_pkg;

	// Register offsets
	localparam logic [7:0] REG_STATUS      = 8'h00;
	localparam logic [7:0] REG_X_HI        = 8'h01;
	localparam logic [7:0] REG_X_LO        = 8'h02;
	localparam logic [7:0] REG_Y_HI        = 8'h03;
	localparam logic [7:0] REG_Y_LO        = 8'h04;
	localparam logic [7:0] REG_Z_HI        = 8'h05;
	localparam logic [7:0] REG_Z_LO        = 8'h06;
	localparam logic [7:0] REG_BUF_SETUP   = 8'h09;
	localparam logic [7:0] REG_TRIG_KEEP   = 8'h0A;
	localparam logic [7:0] REG_SYS_STATE   = 8'h0B;
	localparam logic [7:0] REG_SLEEP_TIME  = 8'h29;
	localparam logic [7:0] REG_SYS_CTRL1   = 8'h2A;
	localparam logic [7:0] REG_POWER       = 8'h2B;
	localparam logic [7:0] REG_WAKE_GATE   = 8'h2C;

	// Field positions
	localparam int CTRL_ACTIVE_BIT    = 0;
	localparam int CTRL_FAST_BIT      = 1;
	localparam int CTRL_WAKE_RATE_LSB = 3;
	localparam int CTRL_RANGE_LSB     = 6;
	localparam int POWER_OSR_LSB      = 0;
	localparam int POWER_AUTO_BIT     = 2;
	localparam int POWER_SLEEP_RATE_LSB = 3;
	localparam int GATE_BUF_HOLD_BIT  = 7;
	localparam int GATE_BUF_INT_BIT   = 6;
	localparam int SETUP_MODE_LSB     = 6;
	localparam int STATUS_OVF_BIT     = 7;
	localparam int STATUS_WMK_BIT     = 6;

	// Reset values
	localparam logic [7:0] RST_REG        = 8'h00;
	localparam logic [7:0] RST_SLEEP_TIME = 8'h10;

	// Oversampling scheme codes
	localparam logic [1:0] OSR_HIGH_RES  = 2'b10;
	localparam logic [1:0] OSR_LOW_POWER = 2'b11;

	// Input scaling: raw samples arrive at 1/4096 g, shifted by this plus the range code, with range code 3 shifted as code 2
	localparam int RAW_SHIFT_BASE = 2;

	typedef enum logic [1:0] {
		BUF_OFF  = 2'b00,
		BUF_CIRC = 2'b01,
		BUF_FILL = 2'b10,
		BUF_TRIG = 2'b11
	} buf_mode_t;

	typedef enum logic [3:0] {
		I2C_IDLE   = 4'b0000,
		I2C_DEV    = 4'b0001,
		I2C_DEVACK = 4'b0010,
		I2C_REG    = 4'b0011,
		I2C_REGACK = 4'b0100,
		I2C_WDATA  = 4'b0101,
		I2C_WACK   = 4'b0110,
		I2C_RDATA  = 4'b0111,
		I2C_RACK   = 4'b1000
	} i2c_state_t;

endpackage : accel_pkg

// >>> src/accel_data_fifo_autowake.sv
// Notes on behaviour
// R01 - Each axis sample is 12-bit two's complement in a high and low byte register.
// R02 - High byte register holds the upper eight bits of each axis sample.
// R03 - Fast-read bit set gives 8-bit results only; cleared gives full 12-bit results.
// R04 - One count is 1/1024, 1/512 or 1/256 g; most negative code is -full-scale.
// R05 - In 8-bit mode one count equals sixteen 12-bit counts.
// R06 - Internal buffer holds 32 samples per axis, filled without host activity.
// R07 - Buffer runs at every data rate and serves 12-bit or 8-bit reads.
// R08 - Buffer modes fill, circular, trigger, disabled chosen in setup register 0x09.
// R09 - Fill mode keeps first 32, flags overflow on a further sample, stores nothing more.
// R10 - Circular mode overwrites the oldest sample, keeping the 32 most recent.
// R11 - Trigger mode keeps samples before the trigger plus a chosen number after.
// R12 - Watermark event when stored count reaches programmed level 1 to 32.
// R13 - Oversampling field 10 in power_scheme_control selects the high-resolution scheme.
// R14 - Oversampling field 11 selects the reduced-oversampling lowest-power scheme.
// R15 - While auto sleep is on, a wake-capable event moves sleep rate to wake rate.
// R16 - Sleep after no qualifying event for longer than the inactivity timeout.
// R17 - Only tap, orientation, motion/freefall and transient events wake; buffer events do not.
// R18 - Buffer gate bit in 0x2C holds buffered data over sleep until flushed.
// R19 - Timeout restarts on wake events and enabled buffer events.
// R20 - A sleep-to-wake transition may signal the host with an interrupt.
// R21 - Host reaches all data and configuration registers over I2C.
// R22 - Buffer reads return oldest first; each read removes the sample and lowers the count.
`timescale 1ns/1ps
module accel_data_fifo_autowake #(
	parameter int         DEPTH    = 32,
	parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               resetn,
	// I2C pins
	input  wire logic               sclIn,
	input  wire logic               sdaIn,
	output logic                    sdaOut,
	output logic                    sdaDriveN,
	// Sensor front end
	input  wire logic               sensorValid,
	input  wire logic signed [15:0] sensorX,
	input  wire logic signed [15:0] sensorY,
	input  wire logic signed [15:0] sensorZ,
	output logic             [2:0]  outputDataRate,
	output logic             [1:0]  oversamplingSelect,
	// Detection events
	input  wire logic               motionEvt,
	input  wire logic               tapEvt,
	input  wire logic               orientEvt,
	input  wire logic               transientEvt,
	input  wire logic               triggerEvt,
	// Host notifications
	output logic                    watermarkIrq,
	output logic                    wakeIrq,
	output logic                    awake
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	function automatic logic [11:0] scaleAxis(input logic signed [15:0] raw, input logic [1:0] rng);
		logic signed [15:0] s;
		s = raw >>> (accel_pkg::RAW_SHIFT_BASE + ((rng == 2'b11) ? 2 : int'(rng)));
		if (s > 16'sd2047)
			return 12'h7FF;
		else if (s < -16'sd2048)
			return 12'h800;
		else
			return s[11:0];
	endfunction : scaleAxis

	// Pin synchronisers
	logic sclS1_r, sclS2_r, sclS3_r;
	logic sdaS1_r, sdaS2_r, sdaS3_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{sclS1_r, sclS2_r, sclS3_r} <= 3'b111;
			{sdaS1_r, sdaS2_r, sdaS3_r} <= 3'b111;
		end else begin
			{sclS1_r, sclS2_r, sclS3_r} <= {sclIn, sclS1_r, sclS2_r};
			{sdaS1_r, sdaS2_r, sdaS3_r} <= {sdaIn, sdaS1_r, sdaS2_r};
		end
	end

	wire sclRise  = sclS2_r & ~sclS3_r;
	wire sclFall  = ~sclS2_r & sclS3_r;
	wire busStart = sclS2_r & sdaS3_r & ~sdaS2_r;
	wire busStop  = sclS2_r & ~sdaS3_r & sdaS2_r;

	// Configuration registers
	logic [7:0] ctrl1_r, power_r, gate_r, setup_r, trigKeep_r, sleepTime_r;

	wire                     active     = ctrl1_r[accel_pkg::CTRL_ACTIVE_BIT];
	wire                     fastRead   = ctrl1_r[accel_pkg::CTRL_FAST_BIT];
	wire [1:0]               rangeSel   = ctrl1_r[accel_pkg::CTRL_RANGE_LSB +: 2];
	wire accel_pkg::buf_mode_t bufMode  = accel_pkg::buf_mode_t'(setup_r[accel_pkg::SETUP_MODE_LSB +: 2]);
	wire [5:0]               wmkLevel   = setup_r[5:0];
	wire                     autoEn     = power_r[accel_pkg::POWER_AUTO_BIT] & active;

	// I2C slave state
	accel_pkg::i2c_state_t state_r;
	logic [7:0] shift_r, ptr_r;
	logic [2:0] bitCnt_r;
	logic       byteDone_r, rw_r;

	wire devMatch = shift_r[7:1] == DEV_ADDR;
	wire wrStrobe = (state_r == accel_pkg::I2C_WDATA) & sclFall & byteDone_r; // [R21]
	wire loadStrobe = sclFall & (((state_r == accel_pkg::I2C_DEVACK) & rw_r) | (state_r == accel_pkg::I2C_RACK));
	wire isHiAddr = (ptr_r == accel_pkg::REG_X_HI) | (ptr_r == accel_pkg::REG_Y_HI) |
		(ptr_r == accel_pkg::REG_Z_HI);
	wire isLoAddr = (ptr_r == accel_pkg::REG_X_LO) | (ptr_r == accel_pkg::REG_Y_LO) |
		(ptr_r == accel_pkg::REG_Z_LO);
	// Fast read steps over the low bytes so a burst gets X, Y, Z high bytes only
	wire [7:0] nextPtr = (fastRead && isHiAddr) ? ptr_r + 8'h02 : ptr_r + 8'h01; // [R03]

	// Sample buffer
	logic [35:0]   mem [DEPTH];
	logic [35:0]   latest_r;
	logic [AW-1:0] wrPtr_r, rdPtr_r;
	logic [CW-1:0] count_r;
	logic          overflow_r, triggered_r, gateHold_r;
	logic [5:0]    postLeft_r;
	logic          asleep_r;
	logic [7:0]    idleCnt_r;

	wire bufOn  = bufMode != accel_pkg::BUF_OFF; // [R08]
	wire full   = count_r == FULL_CNT;
	wire sampleIn = sensorValid & active & bufOn & ~gateHold_r; // [R06] [R07] [R18]
	wire [35:0] newSample = {scaleAxis(sensorX, rangeSel), scaleAxis(sensorY, rangeSel),
		scaleAxis(sensorZ, rangeSel)}; // [R01] [R04]

	logic accept;
	always_comb begin
		unique case (bufMode)
			accel_pkg::BUF_OFF:  accept = 1'b0;
			accel_pkg::BUF_FILL: accept = ~full; // [R09]
			accel_pkg::BUF_CIRC: accept = 1'b1; // [R10]
			accel_pkg::BUF_TRIG: accept = ~triggered_r | (postLeft_r != 6'h00); // [R11]
		endcase
	end

	wire [35:0] head = bufOn ? mem[rdPtr_r] : latest_r;
	wire lastByte = fastRead ? (ptr_r == accel_pkg::REG_Z_HI) : (ptr_r == accel_pkg::REG_Z_LO);
	wire pop      = loadStrobe & bufOn & lastByte & (count_r != '0); // [R22]
	wire push     = sampleIn & accept;
	wire overwrite = push & full;
	wire rdAdv    = pop | overwrite;
	wire ovfSet   = (sampleIn & full & (bufMode == accel_pkg::BUF_FILL)) | (overwrite & ~pop); // [R09]
	wire statusRd = loadStrobe & (ptr_r == accel_pkg::REG_STATUS);
	wire wmHit    = (wmkLevel != 6'h00) & (count_r >= CW'(wmkLevel)); // [R12]
	wire trigNow  = triggerEvt & (bufMode == accel_pkg::BUF_TRIG) & ~triggered_r;
	wire [CW-1:0] countNxt = count_r + CW'(push) - CW'(rdAdv);

	// Register read mux
	logic [7:0] rdData;
	always_comb begin
		rdData = 8'h00;
		unique case (ptr_r)
			accel_pkg::REG_STATUS:     rdData = {overflow_r, wmHit, count_r};
			accel_pkg::REG_X_HI:       rdData = head[35:28]; // [R02] [R05]
			accel_pkg::REG_X_LO:       rdData = fastRead ? 8'h00 : {head[27:24], 4'h0}; // [R03]
			accel_pkg::REG_Y_HI:       rdData = head[23:16];
			accel_pkg::REG_Y_LO:       rdData = fastRead ? 8'h00 : {head[15:12], 4'h0};
			accel_pkg::REG_Z_HI:       rdData = head[11:4];
			accel_pkg::REG_Z_LO:       rdData = fastRead ? 8'h00 : {head[3:0], 4'h0};
			accel_pkg::REG_BUF_SETUP:  rdData = setup_r;
			accel_pkg::REG_TRIG_KEEP:  rdData = trigKeep_r;
			accel_pkg::REG_SYS_STATE:  rdData = {6'h00, triggered_r, ~asleep_r};
			accel_pkg::REG_SLEEP_TIME: rdData = sleepTime_r;
			accel_pkg::REG_SYS_CTRL1:  rdData = ctrl1_r;
			accel_pkg::REG_POWER:      rdData = power_r;
			accel_pkg::REG_WAKE_GATE:  rdData = gate_r;
			default:                   rdData = 8'h00;
		endcase
	end

	// I2C slave: sample on SCL rise, drive on SCL fall
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r    <= accel_pkg::I2C_IDLE;
			shift_r    <= 8'h00;
			ptr_r      <= 8'h00;
			bitCnt_r   <= 3'h0;
			byteDone_r <= 1'b0;
			rw_r       <= 1'b0;
			sdaDriveN  <= 1'b1;
		end else if (busStop) begin
			state_r   <= accel_pkg::I2C_IDLE;
			sdaDriveN <= 1'b1;
		end else if (busStart) begin
			state_r    <= accel_pkg::I2C_DEV;
			bitCnt_r   <= 3'h0;
			byteDone_r <= 1'b0;
			sdaDriveN  <= 1'b1;
		end else begin
			unique case (state_r)
				accel_pkg::I2C_IDLE: begin
					sdaDriveN <= 1'b1;
				end
				accel_pkg::I2C_DEV, accel_pkg::I2C_REG, accel_pkg::I2C_WDATA: begin
					if (sclRise) begin
						shift_r    <= {shift_r[6:0], sdaS2_r};
						bitCnt_r   <= bitCnt_r + 3'h1;
						byteDone_r <= bitCnt_r == 3'h7;
					end else if (sclFall && byteDone_r) begin
						byteDone_r <= 1'b0;
						sdaDriveN  <= 1'b0;
						if (state_r == accel_pkg::I2C_DEV) begin
							rw_r    <= shift_r[0];
							state_r <= devMatch ? accel_pkg::I2C_DEVACK : accel_pkg::I2C_IDLE;
							sdaDriveN <= ~devMatch;
						end else if (state_r == accel_pkg::I2C_REG) begin
							ptr_r   <= shift_r;
							state_r <= accel_pkg::I2C_REGACK;
						end else begin
							ptr_r   <= ptr_r + 8'h01;
							state_r <= accel_pkg::I2C_WACK;
						end
					end
				end
				accel_pkg::I2C_DEVACK, accel_pkg::I2C_REGACK, accel_pkg::I2C_WACK: begin
					if (sclFall) begin
						bitCnt_r <= 3'h0;
						if (loadStrobe) begin
							shift_r   <= rdData;
							sdaDriveN <= rdData[7];
							ptr_r     <= nextPtr;
							state_r   <= accel_pkg::I2C_RDATA;
						end else begin
							sdaDriveN <= 1'b1;
							state_r   <= (state_r == accel_pkg::I2C_DEVACK) ? accel_pkg::I2C_REG :
								accel_pkg::I2C_WDATA;
						end
					end
				end
				accel_pkg::I2C_RDATA: begin
					if (sclFall) begin
						if (bitCnt_r == 3'h7) begin
							sdaDriveN <= 1'b1;
							state_r   <= accel_pkg::I2C_RACK;
						end else begin
							shift_r   <= {shift_r[6:0], 1'b0};
							sdaDriveN <= shift_r[6];
							bitCnt_r  <= bitCnt_r + 3'h1;
						end
					end
				end
				accel_pkg::I2C_RACK: begin
					if (sclRise && sdaS2_r) begin
						state_r <= accel_pkg::I2C_IDLE;
					end else if (sclFall) begin
						shift_r   <= rdData;
						sdaDriveN <= rdData[7];
						ptr_r     <= nextPtr;
						bitCnt_r  <= 3'h0;
						state_r   <= accel_pkg::I2C_RDATA;
					end
				end
				default: begin
					state_r   <= accel_pkg::I2C_IDLE;
					sdaDriveN <= 1'b1;
				end
			endcase
		end
	end

	// Register writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl1_r     <= accel_pkg::RST_REG;
			power_r     <= accel_pkg::RST_REG;
			gate_r      <= accel_pkg::RST_REG;
			setup_r     <= accel_pkg::RST_REG;
			trigKeep_r  <= accel_pkg::RST_REG;
			sleepTime_r <= accel_pkg::RST_SLEEP_TIME;
		end else if (wrStrobe) begin
			unique case (ptr_r)
				accel_pkg::REG_SYS_CTRL1:  ctrl1_r     <= shift_r;
				accel_pkg::REG_POWER:      power_r     <= shift_r; // [R13] [R14]
				accel_pkg::REG_WAKE_GATE:  gate_r      <= shift_r;
				accel_pkg::REG_BUF_SETUP:  setup_r     <= shift_r; // [R08]
				accel_pkg::REG_TRIG_KEEP:  trigKeep_r  <= shift_r;
				accel_pkg::REG_SLEEP_TIME: sleepTime_r <= shift_r;
				default: ;
			endcase
		end
	end

	// Buffer storage has no reset: with the buffer on, data reads show mem[rdPtr_r] whatever the count
	always_ff @(posedge clk) begin
		if (push)
			mem[wrPtr_r] <= newSample;
	end

	wire setupWr = wrStrobe & (ptr_r == accel_pkg::REG_BUF_SETUP);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			latest_r    <= '0;
			wrPtr_r     <= '0;
			rdPtr_r     <= '0;
			count_r     <= '0;
			overflow_r  <= 1'b0;
			triggered_r <= 1'b0;
			postLeft_r  <= 6'h00;
		end else begin
			if (sensorValid && active)
				latest_r <= newSample;
			if (push)
				wrPtr_r <= wrPtr_r + AW'(1);
			if (rdAdv)
				rdPtr_r <= rdPtr_r + AW'(1); // [R10] [R22]
			count_r <= countNxt;
			// A new overflow in the cycle of a status read survives the clear
			if (ovfSet)
				overflow_r <= 1'b1;
			else if (statusRd)
				overflow_r <= 1'b0;
			// A trigger in the cycle of a setup write is not lost
			if (trigNow) begin
				triggered_r <= 1'b1; // [R11]
				postLeft_r  <= trigKeep_r[5:0];
			end else if (setupWr) begin
				triggered_r <= 1'b0;
			end else if (push && triggered_r) begin
				postLeft_r <= postLeft_r - 6'h01;
			end
		end
	end

	// Auto wake and sleep
	wire [3:0] wakeSrc  = {transientEvt, orientEvt, tapEvt, motionEvt};
	wire       qualEvt  = |(wakeSrc & gate_r[3:0]); // [R17]
	logic      wmHitD_r;
	wire       bufEvt   = gate_r[accel_pkg::GATE_BUF_INT_BIT] & ((wmHit & ~wmHitD_r) | ovfSet);
	wire       idleOut  = sensorValid & (idleCnt_r >= sleepTime_r);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			asleep_r   <= 1'b0;
			idleCnt_r  <= 8'h00;
			wakeIrq    <= 1'b0;
			gateHold_r <= 1'b0;
			wmHitD_r   <= 1'b0;
		end else begin
			wmHitD_r <= wmHit;
			wakeIrq  <= autoEn & asleep_r & qualEvt; // [R20]
			if (!autoEn) begin
				asleep_r  <= 1'b0;
				idleCnt_r <= 8'h00;
			end else if (qualEvt || bufEvt) begin
				idleCnt_r <= 8'h00; // [R19]
				if (qualEvt)
					asleep_r <= 1'b0; // [R15]
			end else if (!asleep_r && sensorValid) begin
				if (idleOut)
					asleep_r <= 1'b1; // [R16]
				else
					idleCnt_r <= idleCnt_r + 8'h01;
			end
			// Held data must survive until the host has drained it all
			if (autoEn && !asleep_r && !qualEvt && !bufEvt && idleOut && gate_r[accel_pkg::GATE_BUF_HOLD_BIT])
				gateHold_r <= 1'b1; // [R18]
			else if (count_r == '0)
				gateHold_r <= 1'b0;
		end
	end

	// Registered outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			outputDataRate     <= 3'h0;
			oversamplingSelect <= 2'b00;
			watermarkIrq       <= 1'b0;
			awake              <= 1'b1;
			sdaOut             <= 1'b0;
		end else begin
			outputDataRate     <= asleep_r ? power_r[accel_pkg::POWER_SLEEP_RATE_LSB +: 3] :
				ctrl1_r[accel_pkg::CTRL_WAKE_RATE_LSB +: 3]; // [R15] [R16]
			oversamplingSelect <= power_r[accel_pkg::POWER_OSR_LSB +: 2]; // [R13] [R14]
			watermarkIrq       <= wmHit; // [R12]
			awake              <= ~asleep_r;
			sdaOut             <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	fill_drop_a: assert property ((bufMode == accel_pkg::BUF_FILL) && full && sampleIn && !pop |=> // [R09]
		overflow_r && count_r == FULL_CNT)
		else $error("fill mode full sample did not flag overflow");
	circ_keep_a: assert property ((bufMode == accel_pkg::BUF_CIRC) && full && push && !pop |=> // [R10]
		full && $changed(rdPtr_r))
		else $error("circular mode did not drop oldest");
	count_max_a: assert property (count_r <= FULL_CNT) // [R06]
		else $error("buffer count above depth");
	wmk_flag_a: assert property (wmHit |=> watermarkIrq) // [R12]
		else $error("watermark not raised");
	wake_move_a: assert property (autoEn && asleep_r && qualEvt |=> !asleep_r && wakeIrq ##1 awake) // [R15]
		else $error("wake event did not wake");
	sleep_rate_a: assert property (asleep_r |=> // [R16]
		outputDataRate == $past(power_r[accel_pkg::POWER_SLEEP_RATE_LSB +: 3]))
		else $error("sleep rate not applied");
	buf_nowake_a: assert property (autoEn && asleep_r && !qualEvt |=> asleep_r) // [R17]
		else $error("non wake source woke device");
	gate_hold_a: assert property (gateHold_r |-> !push) // [R18]
		else $error("gated buffer accepted sample");
	fast_low_a: assert property (fastRead && isLoAddr |-> rdData == 8'h00) // [R03]
		else $error("fast read exposed low byte");
	pop_order_a: assert property (pop && !overwrite |=> rdPtr_r == $past(rdPtr_r) + AW'(1) && // [R22]
		count_r == $past(count_r) - CW'(1) + CW'($past(push)))
		else $error("buffer read did not remove oldest");

endmodule : accel_data_fifo_autowake

// >>> sim/i2c_host.sv
`timescale 1ns/1ps
module i2c_host #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	// Clock
	input  wire logic clk,
	// Bus lines
	output logic      scl,
	output logic      sdaLow,
	input  wire logic sdaLine
);
	// Both phases of SCL stay well above the four cycles the slave needs
	localparam int HALF = 6;
	logic [6:0] devAddr = DEV_ADDR;
	logic       ackOk;
	logic [7:0] rd [0:5];
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
		ackOk = 1'b1;
	end
	// SDA moves two cycles after SCL falls, so the slave never sees it change under a high SCL
	task automatic put_bit(input logic b);
		repeat (2) @(posedge clk);
		sdaLow <= ~b;
		repeat (HALF) @(posedge clk);
		scl <= 1'b1;
		repeat (HALF) @(posedge clk);
		scl <= 1'b0;
	endtask : put_bit
	task automatic get_bit(output logic b);
		repeat (2) @(posedge clk);
		sdaLow <= 1'b0;
		repeat (HALF) @(posedge clk);
		scl <= 1'b1;
		repeat (HALF) @(posedge clk);
		b = sdaLine;
		scl <= 1'b0;
	endtask : get_bit
	// Serves as start and as repeated start
	task automatic start_cond();
		repeat (2) @(posedge clk);
		sdaLow <= 1'b0;
		repeat (HALF) @(posedge clk);
		scl <= 1'b1;
		repeat (HALF) @(posedge clk);
		sdaLow <= 1'b1;
		repeat (HALF) @(posedge clk);
		scl <= 1'b0;
	endtask : start_cond
	task automatic stop_cond();
		repeat (2) @(posedge clk);
		sdaLow <= 1'b1;
		repeat (HALF) @(posedge clk);
		scl <= 1'b1;
		repeat (HALF) @(posedge clk);
		sdaLow <= 1'b0;
		repeat (HALF) @(posedge clk);
	endtask : stop_cond
	task automatic send_byte(input logic [7:0] v);
		logic a;
		for (int i = 7; i >= 0; i--) put_bit(v[i]);
		get_bit(a);
		if (a !== 1'b0) ackOk = 1'b0;
	endtask : send_byte
	task automatic get_byte(output logic [7:0] v, input logic last);
		for (int i = 7; i >= 0; i--) get_bit(v[i]);
		put_bit(last);
	endtask : get_byte
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		start_cond();
		send_byte({devAddr, 1'b0});
		send_byte(a);
		send_byte(d);
		stop_cond();
	endtask : write_reg
	task automatic read_regs(input logic [7:0] a, input int n);
		start_cond();
		send_byte({devAddr, 1'b0});
		send_byte(a);
		start_cond();
		send_byte({devAddr, 1'b1});
		for (int i = 0; i < n; i++) get_byte(rd[i], i == n - 1);
		stop_cond();
	endtask : read_regs
endmodule : i2c_host

// >>> sim/accel_data_fifo_autowake_test.sv
`timescale 1ns/1ps
module accel_data_fifo_autowake_test;
	// Stimulus
	logic               clk = 1'b0;
	logic               resetn = 1'b0;
	logic               sensorValid = 1'b0;
	logic signed [15:0] sensorX = 16'sh0000;
	logic signed [15:0] sensorY = 16'sh0000;
	logic signed [15:0] sensorZ = 16'sh0000;
	logic        [4:0]  evts = 5'h00;
	// Observed
	logic               sdaOut;
	logic               sdaDriveN;
	logic               scl;
	logic               sdaLow;
	logic        [2:0]  outputDataRate;
	logic        [1:0]  oversamplingSelect;
	logic               watermarkIrq;
	logic               wakeIrq;
	logic               awake;
	wire                sdaLine = ~(sdaLow | ~sdaDriveN);
	int                 n_errors = 0;
	int                 checks_done = 0;
	int                 cycles = 0;
	int                 wakes = 0;
	int                 w;
	logic        [11:0] e [3];
	logic        [7:0]  zeroRegs [6] = '{8'h00, 8'h09, 8'h2B, 8'h2C, 8'h2A, 8'h40};
	always #4 clk = ~clk;
	accel_data_fifo_autowake dut (
		.clk(clk), .resetn(resetn), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaDriveN(sdaDriveN),
		.sensorValid(sensorValid), .sensorX(sensorX), .sensorY(sensorY), .sensorZ(sensorZ),
		.outputDataRate(outputDataRate), .oversamplingSelect(oversamplingSelect),
		.motionEvt(evts[0]), .tapEvt(evts[1]), .orientEvt(evts[2]), .transientEvt(evts[3]),
		.triggerEvt(evts[4]), .watermarkIrq(watermarkIrq), .wakeIrq(wakeIrq), .awake(awake)
	);
	i2c_host host (.clk(clk), .scl(scl), .sdaLow(sdaLow), .sdaLine(sdaLine));
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up
	// Counts pulse cycles of the wake interrupt and cuts a hang short
	always @(posedge clk) begin
		cycles++;
		if (wakeIrq === 1'b1) wakes++;
		if (cycles == 80000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic push(input logic signed [15:0] x, input logic signed [15:0] y, input logic signed [15:0] z);
		@(posedge clk);
		sensorValid <= 1'b1;
		sensorX <= x;
		sensorY <= y;
		sensorZ <= z;
		@(posedge clk);
		sensorValid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : push
	task automatic pulse(input int k);
		@(posedge clk);
		evts <= 5'h01 << k;
		@(posedge clk);
		evts <= 5'h00;
		repeat (4) @(posedge clk);
	endtask : pulse
	// Saturating 12-bit view of a raw sample at the given shift
	function automatic logic [11:0] scale(input logic signed [15:0] raw, input int sh);
		logic signed [15:0] v;
		v = raw >>> sh;
		if (v > 16'sh07FF) return 12'h800 - 12'h001;
		if (v < -16'sh0800) return 12'h800;
		return v[11:0];
	endfunction : scale
	task automatic chk_xyz(input logic fast);
		host.read_regs(accel_pkg::REG_X_HI, fast ? 3 : 6);
		for (int i = 0; i < 3; i++) begin
			if (fast) begin
				check(host.rd[i], e[i][11:4]);
			end else begin
				check(host.rd[2 * i], e[i][11:4]);
				check(host.rd[2 * i + 1], {e[i][3:0], 4'h0});
			end
		end
	endtask : chk_xyz
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		check({7'h00, awake}, 8'h01);
		check({3'h0, sdaOut, sdaDriveN, outputDataRate}, 8'h08);
		repeat (4) @(posedge clk);
		foreach (zeroRegs[i]) begin
			host.read_regs(zeroRegs[i], 1);
			check(host.rd[0], 8'h00);
		end
		host.read_regs(accel_pkg::REG_SLEEP_TIME, 1);
		check(host.rd[0], 8'h10);
		// Wrong bus address must go unanswered and change nothing
		host.devAddr = 7'h2B;
		host.write_reg(accel_pkg::REG_SLEEP_TIME, 8'h55);
		check({7'h00, host.ackOk}, 8'h00);
		host.devAddr = 7'h2A;
		host.ackOk = 1'b1;
		host.read_regs(accel_pkg::REG_SLEEP_TIME, 1);
		check(host.rd[0], 8'h10);
		foreach (e[i]) begin
			if (i < 2) begin
				host.write_reg(8'h2B, {6'h00, i == 0 ? accel_pkg::OSR_HIGH_RES : accel_pkg::OSR_LOW_POWER});
				check({6'h00, oversamplingSelect}, {6'h00, 2'b10 + 2'(i)});
			end
		end
		for (int r = 0; r < 3; r++) begin
			host.write_reg(accel_pkg::REG_SYS_CTRL1, {r[1:0], 6'h01});
			push(16'sh8000, 16'sh1234, 16'sh7FFF);
			e = '{12'h800, scale(16'sh1234, 2 + r), scale(16'sh7FFF, 2 + r)};
			chk_xyz(1'b0);
		end
		host.write_reg(accel_pkg::REG_SYS_CTRL1, 8'h03);
		push(16'sh1000, -16'sh1000, 16'sh0040);
		e = '{12'h400, 12'hC00, 12'h010};
		chk_xyz(1'b1);
		host.read_regs(accel_pkg::REG_X_LO, 1);
		check(host.rd[0], 8'h00);
		// Fill mode, watermark 32: the 33rd sample is refused and flagged
		host.write_reg(accel_pkg::REG_SYS_CTRL1, 8'h01);
		host.write_reg(8'h09, 8'hA0);
		for (int i = 0; i < 33; i++) push(16'((i + 1) * 64), 16'sh0000, 16'sh0000);
		check({7'h00, watermarkIrq}, 8'h01);
		host.read_regs(accel_pkg::REG_STATUS, 1);
		check(host.rd[0], 8'hE0);
		host.read_regs(accel_pkg::REG_STATUS, 1);
		check(host.rd[0], 8'h60);
		host.read_regs(accel_pkg::REG_X_HI, 6);
		check(host.rd[0], 8'h01);
		host.read_regs(accel_pkg::REG_STATUS, 1);
		check(host.rd[0], 8'h1F);
		check({7'h00, watermarkIrq}, 8'h00);
		// Circular mode, watermark 31: the second extra sample overwrites the oldest
		host.write_reg(8'h09, 8'h5F);
		check({7'h00, watermarkIrq}, 8'h01);
		push(16'sh0A00, 16'sh0000, 16'sh0000);
		push(16'sh0A40, 16'sh0000, 16'sh0000);
		host.read_regs(accel_pkg::REG_STATUS, 1);
		check(host.rd[0], 8'hE0);
		host.read_regs(accel_pkg::REG_X_HI, 6);
		check(host.rd[0], 8'h03);
		// Trigger mode, keep one: the post-trigger sample overwrites the oldest, the next is refused
		host.write_reg(accel_pkg::REG_TRIG_KEEP, 8'h01);
		host.write_reg(8'h09, 8'hC0);
		push(16'sh0C00, 16'sh0000, 16'sh0000);
		pulse(4);
		push(16'sh0C40, 16'sh0000, 16'sh0000);
		push(16'sh0C80, 16'sh0000, 16'sh0000);
		host.read_regs(accel_pkg::REG_SYS_STATE, 1);
		check(host.rd[0], 8'h03);
		host.read_regs(accel_pkg::REG_X_HI, 6);
		check(host.rd[0], 8'h05);
		// Auto sleep after three idle samples, motion only may wake, buffer held over sleep
		host.write_reg(8'h09, 8'h40);
		host.write_reg(accel_pkg::REG_SLEEP_TIME, 8'h03);
		host.write_reg(8'h2C, 8'h81);
		host.write_reg(accel_pkg::REG_SYS_CTRL1, 8'h29);
		host.write_reg(8'h2B, 8'h14);
		repeat (4) push(16'sh0000, 16'sh0000, 16'sh0000);
		check({5'h00, awake, outputDataRate[1:0]}, 8'h02);
		host.read_regs(accel_pkg::REG_STATUS, 1);
		check(host.rd[0], 8'hA0);
		push(16'sh0E00, 16'sh0000, 16'sh0000);
		host.read_regs(accel_pkg::REG_STATUS, 1);
		check(host.rd[0], 8'h20);
		w = wakes;
		pulse(1);
		pulse(4);
		check({7'h00, awake}, 8'h00);
		pulse(0);
		check(8'(wakes - w), 8'h01);
		check({4'h0, awake, outputDataRate}, 8'h0D);
		repeat (2) push(16'sh0000, 16'sh0000, 16'sh0000);
		pulse(0);
		repeat (2) push(16'sh0000, 16'sh0000, 16'sh0000);
		check({7'h00, awake}, 8'h01);
		repeat (2) push(16'sh0000, 16'sh0000, 16'sh0000);
		check({7'h00, awake}, 8'h00);
		check({7'h00, host.ackOk}, 8'h01);
		wrap_up();
	end
endmodule : accel_data_fifo_autowake_test
